// ### pkg/rtct_params.svh
// rtct_params.svh: register offsets, field positions, reset values, timing
// assumes a 32-bit word register port with byte addresses
`ifndef RTCT_PARAMS_SVH
`define RTCT_PARAMS_SVH

// ---------------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------------
`define RTCT_OFS_CTRL   6'h00
`define RTCT_OFS_SYNC   6'h04
`define RTCT_OFS_COUNT  6'h08
`define RTCT_OFS_FLAG   6'h0c
`define RTCT_OFS_MASK   6'h10
`define RTCT_OFS_EVENT_CONTROL 6'h14
`define RTCT_OFS_TCTRL  6'h18
`define RTCT_OFS_TID    6'h1c
`define RTCT_OFS_STAMP  6'h20
`define RTCT_OFS_GP0    6'h24

// ---------------------------------------------------------------------
// field positions
// ---------------------------------------------------------------------
`define RTCT_CTRL_EN    0
`define RTCT_CTRL_CSYNC 1
`define RTCT_CTRL_MODE  2
`define RTCT_CTRL_PSEL  4
`define RTCT_CTRL_DMAJ  8
`define RTCT_TC_ACT     0
`define RTCT_TC_FALL    2
`define RTCT_TC_GPCLR   3
`define RTCT_FLAG_TAMP  0
`define RTCT_FLAG_PER   1

// ---------------------------------------------------------------------
// reset values and timing
// ---------------------------------------------------------------------
`define RTCT_RST_WORD   32'h0000_0000
`define RTCT_RST_FLAGS  9'h000
`define RTCT_SYNC_STG   2
`define RTCT_GP_WORDS   4

`endif

// ### pkg/rtct_pkg.sv
// rtct_pkg.sv: types of the tamper rtc
// assumes rtct_params.svh holds all numeric constants
package rtct_pkg;

    typedef enum logic [1:0] {
        RTCT_MODE_CNT32 = 2'h0,
        RTCT_MODE_CNT16 = 2'h1,
        RTCT_MODE_CLOCK = 2'h2,
        RTCT_MODE_RSVD  = 2'h3
    } rtct_mode_t;

    typedef enum logic [1:0] {
        RTCT_ACT_OFF   = 2'h0,
        RTCT_ACT_WAKE  = 2'h1,
        RTCT_ACT_STAMP = 2'h2,
        RTCT_ACT_LAYER = 2'h3
    } rtct_act_t;

    typedef enum logic {
        RTCT_DET_IDLE = 1'b0,
        RTCT_DET_PEND = 1'b1
    } rtct_det_t;

endpackage : rtct_pkg

// ### design/rtct_gp_mem.sv
// rtct_gp_mem.sv: general purpose word store with registered read
// assumes one write port and a wipe input on the same clock
`timescale 1ns/1ps
`include "rtct_params.svh"
module rtct_gp_mem (
    input  wire logic        clk_in,
    input  wire logic        rst_b_in,
    input  wire logic        wr_in,
    input  wire logic [1:0]  wr_idx_in,
    input  wire logic [31:0] wr_data_in,
    input  wire logic [1:0]  rd_idx_in,
    input  wire logic        wipe_in,
    output logic      [31:0] rd_data_out
);
    logic [31:0] word_reg [`RTCT_GP_WORDS];

    genvar gi;
    generate
        for (gi = 0; gi < `RTCT_GP_WORDS; gi++) begin : g_word
            always_ff @(posedge clk_in or negedge rst_b_in) begin
                if (!rst_b_in) begin
                    word_reg[gi] <= `RTCT_RST_WORD;
                end else if (wipe_in) begin
                    word_reg[gi] <= `RTCT_RST_WORD;
                end else if (wr_in && wr_idx_in == 2'(gi)) begin
                    word_reg[gi] <= wr_data_in;
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rd_data_out <= `RTCT_RST_WORD;
        end else begin
            rd_data_out <= word_reg[rd_idx_in];
        end
    end

    AST_GP_WIPE: assert property (@(posedge clk_in) disable iff (!rst_b_in)
        wipe_in |=> (word_reg[0] == 32'h0) && (word_reg[3] == 32'h0))
        else $error("general purpose words not wiped by tamper");

endmodule : rtct_gp_mem

// ### design/rtct_top.sv
// rtct_top.sv: counter with tamper capture, periodic events, interrupt
// assumes word register port, tamper and external reset pins asynchronous
//
// Our own choices: strobed register access and the register offsets.
`timescale 1ns/1ps
`include "rtct_params.svh"
module rtct_top (
    input  wire logic        clk_in,
    input  wire logic        rst_b_in,
    input  wire logic [5:0]  addr_in,
    input  wire logic [31:0] wdata_in,
    input  wire logic        wr_in,
    input  wire logic        rd_in,
    output logic      [31:0] rdata_out,
    input  wire logic        tamper_pin_in,
    input  wire logic        ext_rst_b_in,
    output logic             irq_out,
    output logic      [7:0]  periodic_event_out
);
    function automatic logic hit(input logic [5:0] a, input logic [5:0] ofs);
        return a == ofs;
    endfunction : hit

    // ---------------------------------------------------------------------
    // pin synchronisers
    // ---------------------------------------------------------------------
    logic [1:0] tamp_sync_reg;
    logic [1:0] xrst_sync_reg;
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            tamp_sync_reg <= 2'h0;
            xrst_sync_reg <= 2'h3;
        end else begin
            tamp_sync_reg <= {tamp_sync_reg[0], tamper_pin_in};
            xrst_sync_reg <= {xrst_sync_reg[0], ext_rst_b_in};
        end
    end
    wire tamp_lvl = tamp_sync_reg[1];
    wire xrst_act = !xrst_sync_reg[1];

    // ---------------------------------------------------------------------
    // address decode
    // ---------------------------------------------------------------------
    wire [5:0] gp_ofs   = addr_in - `RTCT_OFS_GP0;
    wire       gp_hit   = addr_in >= `RTCT_OFS_GP0 && gp_ofs[5:4] == 2'h0
                          && gp_ofs[1:0] == 2'h0;
    wire       wr_ctrl  = wr_in && hit(addr_in, `RTCT_OFS_CTRL);
    wire       wr_count = wr_in && hit(addr_in, `RTCT_OFS_COUNT);
    wire       wr_flag  = wr_in && hit(addr_in, `RTCT_OFS_FLAG);
    wire       wr_mask  = wr_in && hit(addr_in, `RTCT_OFS_MASK);
    wire       wr_ev    = wr_in && hit(addr_in, `RTCT_OFS_EVENT_CONTROL);
    wire       wr_tc    = wr_in && hit(addr_in, `RTCT_OFS_TCTRL);
    wire       wr_tid   = wr_in && hit(addr_in, `RTCT_OFS_TID);
    wire       rd_count = rd_in && hit(addr_in, `RTCT_OFS_COUNT);
    wire       rd_flag  = rd_in && hit(addr_in, `RTCT_OFS_FLAG);
    wire       rd_stamp = rd_in && hit(addr_in, `RTCT_OFS_STAMP);

    // ---------------------------------------------------------------------
    // control registers
    // ---------------------------------------------------------------------
    logic                 en_req_reg;
    logic                 csync_req_reg;
    rtct_pkg::rtct_mode_t mode_reg;
    logic [3:0]           psel_reg;
    logic                 dmaj_reg;
    logic [8:0]           mask_reg;
    logic [7:0]           event_control_reg;
    rtct_pkg::rtct_act_t  act_reg;
    logic                 fall_reg;
    logic                 gpclr_reg;
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            en_req_reg    <= 1'b0;
            csync_req_reg <= 1'b0;
            mode_reg      <= rtct_pkg::RTCT_MODE_CNT32;
            psel_reg      <= 4'h0;
            dmaj_reg      <= 1'b0;
            mask_reg      <= `RTCT_RST_FLAGS;
            event_control_reg    <= 8'h00;
            act_reg       <= rtct_pkg::RTCT_ACT_OFF;
            fall_reg      <= 1'b0;
            gpclr_reg     <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                en_req_reg    <= wdata_in[`RTCT_CTRL_EN];
                csync_req_reg <= wdata_in[`RTCT_CTRL_CSYNC];
                mode_reg      <= rtct_pkg::rtct_mode_t'(wdata_in[`RTCT_CTRL_MODE +: 2]);
                psel_reg      <= wdata_in[`RTCT_CTRL_PSEL +: 4];
                dmaj_reg      <= wdata_in[`RTCT_CTRL_DMAJ];
            end
            if (wr_mask) mask_reg <= wdata_in[8:0];
            if (wr_ev) event_control_reg <= wdata_in[7:0];
            if (wr_tc) begin
                act_reg   <= rtct_pkg::rtct_act_t'(wdata_in[`RTCT_TC_ACT +: 2]);
                fall_reg  <= wdata_in[`RTCT_TC_FALL];
                gpclr_reg <= wdata_in[`RTCT_TC_GPCLR];
            end
        end
    end

    // ---------------------------------------------------------------------
    // control crossing into the count path and pending flags
    // ---------------------------------------------------------------------
    logic [`RTCT_SYNC_STG-1:0] en_pipe_reg;
    logic [`RTCT_SYNC_STG-1:0] cs_pipe_reg;
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            en_pipe_reg <= '0;
            cs_pipe_reg <= '0;
        end else begin
            en_pipe_reg <= {en_pipe_reg[0], en_req_reg};
            cs_pipe_reg <= {cs_pipe_reg[0], csync_req_reg};
        end
    end
    wire en_eff   = en_pipe_reg[`RTCT_SYNC_STG-1];
    wire cs_eff   = cs_pipe_reg[`RTCT_SYNC_STG-1];
    wire busy_en  = en_req_reg != en_eff;
    wire busy_cs  = csync_req_reg != cs_eff;

    // ---------------------------------------------------------------------
    // prescaler, periodic events and counter
    // ---------------------------------------------------------------------
    logic [15:0] presc_reg;
    logic [31:0] count_reg;
    wire  [15:0] presc_inc  = presc_reg + 16'h0001;
    wire  [15:0] presc_rise = en_eff ? (presc_inc & ~presc_reg) : 16'h0000;
    // majority debounce only widens the feature gate, it never filters
    wire tamp_feat = act_reg != rtct_pkg::RTCT_ACT_OFF || dmaj_reg;
    wire per_ok    = psel_reg != 4'h0 || tamp_feat;
    wire [7:0] per_fire = per_ok ? presc_rise[7:0] : 8'h00;
    wire tick = psel_reg == 4'h0 ? en_eff : presc_rise[4'(psel_reg - 4'h1)];
    wire is16 = mode_reg == rtct_pkg::RTCT_MODE_CNT16;
    wire [31:0] cnt_tick = is16 ? {16'h0000, count_reg[15:0] + 16'h0001}
                                : count_reg + 32'h0000_0001;
    wire [31:0] cnt_wr   = is16 ? {16'h0000, wdata_in[15:0]} : wdata_in;
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            presc_reg <= 16'h0000;
            count_reg <= `RTCT_RST_WORD;
        end else begin
            presc_reg <= en_eff ? presc_inc : 16'h0000;
            if (wr_count) count_reg <= cnt_wr;
            else if (tick) count_reg <= cnt_tick;
        end
    end

    // ---------------------------------------------------------------------
    // count read synchronisation
    // ---------------------------------------------------------------------
    logic        cs_prev_reg;
    logic        stale_reg;
    logic [31:0] snap_reg;
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            cs_prev_reg <= 1'b0;
            stale_reg   <= 1'b0;
            snap_reg    <= `RTCT_RST_WORD;
        end else begin
            cs_prev_reg <= cs_eff;
            // the copy is frozen until the first read after enabling
            if (cs_eff && !cs_prev_reg) stale_reg <= 1'b1;
            else if (rd_count) stale_reg <= 1'b0;
            if (cs_eff && !stale_reg) snap_reg <= count_reg;
        end
    end
    wire [31:0] count_rd = cs_eff ? snap_reg : count_reg;

    // ---------------------------------------------------------------------
    // tamper detection
    // ---------------------------------------------------------------------
    rtct_pkg::rtct_det_t det_reg;
    logic        tprev_reg;
    logic        skip_reg;
    logic        lock_reg;
    logic        tid_reg;
    logic [31:0] stamp_reg;
    logic [8:0]  flag_reg;
    wire act_on   = act_reg != rtct_pkg::RTCT_ACT_OFF;
    wire layer    = act_reg == rtct_pkg::RTCT_ACT_LAYER;
    // majority debounce is not applied, the raw synced edge is used
    wire tedge    = fall_reg ? (tprev_reg && !tamp_lvl) : (!tprev_reg && tamp_lvl);
    wire armed    = act_on && (en_eff || layer);
    wire det_fire = det_reg == rtct_pkg::RTCT_DET_PEND && !xrst_act;
    wire tamp_set = det_fire && en_eff;
    wire cap      = det_fire && !lock_reg && !skip_reg;
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            det_reg <= rtct_pkg::RTCT_DET_IDLE;
        end else begin
            case (det_reg)
                rtct_pkg::RTCT_DET_IDLE: begin
                    if (armed && tedge) det_reg <= rtct_pkg::RTCT_DET_PEND;
                end
                rtct_pkg::RTCT_DET_PEND: begin
                    det_reg <= rtct_pkg::RTCT_DET_IDLE;
                end
                default: begin
                    det_reg <= rtct_pkg::RTCT_DET_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            tprev_reg <= 1'b0;
            skip_reg  <= 1'b0;
            lock_reg  <= 1'b0;
            stamp_reg <= `RTCT_RST_WORD;
        end else begin
            tprev_reg <= act_on ? tamp_lvl : 1'b0;
            if (det_reg == rtct_pkg::RTCT_DET_PEND && xrst_act) skip_reg <= 1'b1;
            else if (det_fire) skip_reg <= 1'b0;
            if (cap) lock_reg <= 1'b1;
            else if (rd_stamp) lock_reg <= 1'b0;
            if (cap) stamp_reg <= count_reg;
        end
    end

    // ---------------------------------------------------------------------
    // flags, source id, interrupt and event outputs
    // ---------------------------------------------------------------------
    // reading the timestamp is not a clear source; read of flags or w1c is
    wire [8:0] flg_clr = rd_flag ? 9'h1ff : (wr_flag ? wdata_in[8:0] : 9'h000);
    wire [8:0] flg_set = {per_fire, tamp_set};
    wire [8:0] flg_next = (flag_reg & ~flg_clr) | flg_set;
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            flag_reg           <= `RTCT_RST_FLAGS;
            tid_reg            <= 1'b0;
            irq_out            <= 1'b0;
            periodic_event_out <= 8'h00;
        end else begin
            flag_reg           <= flg_next;
            tid_reg            <= tamp_set || (tid_reg && !(wr_tid && wdata_in[0]));
            irq_out            <= |(flag_reg & mask_reg);
            periodic_event_out <= per_fire & event_control_reg;
        end
    end

    // ---------------------------------------------------------------------
    // read port and general purpose store
    // ---------------------------------------------------------------------
    wire [31:0] ctrl_rd = {23'h0, dmaj_reg, psel_reg, mode_reg, csync_req_reg, en_req_reg};
    wire [31:0] rd_mux =
        hit(addr_in, `RTCT_OFS_CTRL)   ? ctrl_rd :
        hit(addr_in, `RTCT_OFS_SYNC)   ? {30'h0, busy_cs, busy_en} :
        hit(addr_in, `RTCT_OFS_COUNT)  ? count_rd :
        hit(addr_in, `RTCT_OFS_FLAG)   ? {23'h0, flag_reg} :
        hit(addr_in, `RTCT_OFS_MASK)   ? {23'h0, mask_reg} :
        hit(addr_in, `RTCT_OFS_EVENT_CONTROL) ? {24'h0, event_control_reg} :
        hit(addr_in, `RTCT_OFS_TCTRL)  ? {28'h0, gpclr_reg, fall_reg, act_reg} :
        hit(addr_in, `RTCT_OFS_TID)    ? {31'h0, tid_reg} :
        hit(addr_in, `RTCT_OFS_STAMP)  ? stamp_reg : 32'h0000_0000;
    logic [31:0] rdata_reg;
    logic        gp_sel_reg;
    logic [31:0] gp_rd;
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rdata_reg  <= `RTCT_RST_WORD;
            gp_sel_reg <= 1'b0;
        end else begin
            rdata_reg  <= rd_in ? rd_mux : 32'h0000_0000;
            gp_sel_reg <= rd_in && gp_hit;
        end
    end
    assign rdata_out = gp_sel_reg ? gp_rd : rdata_reg;

    rtct_gp_mem u_gp (
        .clk_in      (clk_in),
        .rst_b_in    (rst_b_in),
        .wr_in       (wr_in && gp_hit),
        .wr_idx_in   (gp_ofs[3:2]),
        .wr_data_in  (wdata_in),
        .rd_idx_in   (gp_ofs[3:2]),
        .wipe_in     (det_fire),
        .rd_data_out (gp_rd)
    );

    // ---------------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);

    AST_STALE_HOLD: assert property (cs_eff && stale_reg |=> $stable(snap_reg))
        else $error("sync copy moved before first read");
    AST_DETECT: assert property (det_reg == rtct_pkg::RTCT_DET_IDLE && armed && tedge
        |=> det_reg == rtct_pkg::RTCT_DET_PEND)
        else $error("edge not taken as detection");
    AST_SKIP_SET: assert property (det_reg == rtct_pkg::RTCT_DET_PEND && xrst_act
        |=> skip_reg && det_reg == rtct_pkg::RTCT_DET_IDLE)
        else $error("external reset during detection not recorded");
    AST_SKIP_NOUPD: assert property (det_fire && skip_reg |=> $stable(stamp_reg))
        else $error("timestamp updated after aborted detection");
    AST_PER_OFF: assert property (psel_reg == 4'h0 && !tamp_feat |-> per_fire == 8'h00)
        else $error("periodic fired with prescaler off and no tamper");
    AST_PER_ON: assert property (psel_reg == 4'h0 && act_on && presc_rise[0]
        |=> periodic_event_out[0] == $past(event_control_reg[0]) && flag_reg[`RTCT_FLAG_PER])
        else $error("periodic missing with tamper on and prescaler off");
    AST_READ_NOCLR: assert property (flag_reg[0] && rd_stamp && !wr_in |=> flag_reg[0])
        else $error("timestamp read cleared intrusion flag");
    AST_LAYER_NOFLAG: assert property (det_fire && !en_eff && !flag_reg[0]
        |=> !flag_reg[0])
        else $error("flag set by disabled active layer detection");
    AST_CAPTURE: assert property (det_fire && en_eff && !lock_reg && !skip_reg
        |=> lock_reg && stamp_reg == $past(count_reg) && flag_reg[0] && tid_reg)
        else $error("tamper capture incomplete");
    AST_BUSY: assert property (wr_ctrl && wdata_in[`RTCT_CTRL_EN] != en_req_reg
        ##1 !wr_ctrl [*2] |-> busy_en && $past(busy_en) ##1 !busy_en)
        else $error("enable pending timing wrong");
    AST_IRQ: assert property (|(flag_reg & mask_reg) |=> irq_out)
        else $error("unmasked flag without interrupt");

    COV_CAPTURE: cover property (cap ##1 rd_stamp);
    COV_PER_OFF: cover property (psel_reg == 4'h0 && act_on && per_fire[3]);
    COV_STALE: cover property (stale_reg && rd_count);
    COV_SKIP: cover property (skip_reg ##[1:50] det_fire);

endmodule : rtct_top

// ### sim/rtct_tamper_src.sv
// rtct_tamper_src.sv: far-side model of the tamper pin and external reset pin
// assumes the bench moves the pin through set_pin just after a rising edge
`timescale 1ns/1ps
module rtct_tamper_src (
    input  wire logic clk_in,
    output logic      pin_out,
    output logic      ext_rst_b_out
);
    initial begin
        pin_out       = 1'b0;
        ext_rst_b_out = 1'b1;
    end
    // --------------------------------------------------------------
    // pin level changes, registered on the clock like the bench
    // --------------------------------------------------------------
    task automatic set_pin(input logic v);
        @(posedge clk_in);
        pin_out <= v;
    endtask : set_pin
    // pin change followed by a one-cycle external reset pulse
    task automatic set_pin_rst(input logic v);
        @(posedge clk_in);
        pin_out <= v;
        @(posedge clk_in);
        ext_rst_b_out <= 1'b0;
        @(posedge clk_in);
        ext_rst_b_out <= 1'b1;
    endtask : set_pin_rst
endmodule : rtct_tamper_src

// ### sim/rtc_counter_tamper_detect_tb.sv
// rtc_counter_tamper_detect_tb.sv: self-checking bench of rtct_top
// assumes rtct_tamper_src as the tamper side and a 40 MHz clock
`timescale 1ns/1ps
`include "rtct_params.svh"
module rtc_counter_tamper_detect_tb;
    logic        clk_in, rst_b_in, wr_in, rd_in, tamp, ext_b, irq_out;
    logic [5:0]  addr_in;
    logic [31:0] wdata_in, rdata_out, d;
    logic [7:0]  periodic_event_out;
    int          miscompares, check_count, n;
    rtct_top dut (.clk_in(clk_in), .rst_b_in(rst_b_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
        .tamper_pin_in(tamp), .ext_rst_b_in(ext_b), .irq_out(irq_out),
        .periodic_event_out(periodic_event_out));
    rtct_tamper_src src (.clk_in(clk_in), .pin_out(tamp), .ext_rst_b_out(ext_b));
    initial begin
        clk_in = 1'b0;
        forever #12.5 clk_in = ~clk_in;
    end
    // --------------------------------------------------------------
    // bus tasks and compare
    // --------------------------------------------------------------
    task automatic wr(input logic [5:0] a, input logic [31:0] v);
        @(posedge clk_in);
        wr_in <= 1'b1; addr_in <= a; wdata_in <= v;
        @(posedge clk_in);
        wr_in <= 1'b0;
    endtask : wr
    task automatic rd(input logic [5:0] a);
        @(posedge clk_in);
        rd_in <= 1'b1; addr_in <= a;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1 d = rdata_out;
    endtask : rd
    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : cmp
    task automatic count_events(input int cyc);
        n = 0;
        repeat (cyc) begin
            @(posedge clk_in);
            #1 if (periodic_event_out !== 8'h00) n++;
        end
    endtask : count_events
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : report_and_stop
    // --------------------------------------------------------------
    // scenarios
    // --------------------------------------------------------------
    task automatic t_reset_and_sync;
        rd(`RTCT_OFS_FLAG);
        cmp("flags", 32'h0000_0000, d);
        rd(6'h3c);
        cmp("unmapped", 32'h0000_0000, d);
        wr(`RTCT_OFS_CTRL, 32'h0000_0001);
        rd(`RTCT_OFS_SYNC);
        cmp("sync_busy", 32'h0000_0001, d & 32'h1);
        rd(`RTCT_OFS_SYNC);
        cmp("sync_done", 32'h0000_0000, d & 32'h3);
    endtask : t_reset_and_sync
    task automatic t_periodic;
        wr(`RTCT_OFS_EVENT_CONTROL, 32'h0000_00ff);
        count_events(16);
        cmp("ev_gated", 32'h0, n);
        wr(`RTCT_OFS_TCTRL, 32'h0000_0001);
        count_events(16);
        cmp("ev_tamper_on", 32'h1, n > 0);
        wr(`RTCT_OFS_EVENT_CONTROL, 32'h0000_0000);
        wr(`RTCT_OFS_MASK, 32'h0000_0000);
        count_events(16);
        cmp("ev_cleared", 32'h0, n);
    endtask : t_periodic
    task automatic t_count;
        logic [31:0] first;
        wr(`RTCT_OFS_CTRL, 32'h0000_0000);
        wr(`RTCT_OFS_COUNT, 32'h1234_5678);
        rd(`RTCT_OFS_COUNT);
        cmp("counter_32bit_mode", 32'h1234_5678, d);
        wr(`RTCT_OFS_CTRL, 32'h0000_0004);
        wr(`RTCT_OFS_COUNT, 32'hffff_abcd);
        rd(`RTCT_OFS_COUNT);
        cmp("counter_16bit_mode", 32'h0000_abcd, d);
        wr(`RTCT_OFS_CTRL, 32'h0000_0003);
        repeat (3) @(posedge clk_in);
        rd(`RTCT_OFS_COUNT);
        first = d;
        cmp("count_stale", 32'h0000_abcd, first);
        n = 0;
        while (d == first && n < 8) begin
            rd(`RTCT_OFS_COUNT);
            n++;
        end
        cmp("count_moved", 32'h1, d != first);
    endtask : t_count
    task automatic t_tamper;
        logic [31:0] c;
        wr(`RTCT_OFS_GP0, 32'h0000_005a);
        wr(`RTCT_OFS_TCTRL, 32'h0000_0006);
        wr(`RTCT_OFS_MASK, 32'h0000_0001);
        src.set_pin(1'b1);
        repeat (8) @(posedge clk_in);
        #1 cmp("irq_rise_ignored", 32'h0, irq_out);
        src.set_pin(1'b0);
        repeat (8) @(posedge clk_in);
        #1 cmp("irq_tamper", 32'h1, irq_out);
        rd(`RTCT_OFS_TID);
        cmp("source_id", 32'h1, d & 32'h1);
        rd(`RTCT_OFS_STAMP);
        #1 cmp("irq_after_stamp", 32'h1, irq_out);
        rd(`RTCT_OFS_GP0);
        cmp("gp_wiped", 32'h0, d);
        rd(`RTCT_OFS_COUNT);
        c = d;
        wr(6'h28, c);
        rd(6'h28);
        cmp("gp_copy", c, d);
        wr(`RTCT_OFS_FLAG, 32'h0000_0001);
        repeat (2) @(posedge clk_in);
        #1 cmp("irq_cleared", 32'h0, irq_out);
    endtask : t_tamper
    task automatic pulse_tamper(input logic with_rst);
        src.set_pin(1'b0);
        repeat (4) @(posedge clk_in);
        if (with_rst) src.set_pin_rst(1'b1);
        else src.set_pin(1'b1);
        repeat (6) @(posedge clk_in);
    endtask : pulse_tamper
    task automatic clear_tamper;
        wr(`RTCT_OFS_TID, 32'h0000_0001);
        wr(`RTCT_OFS_FLAG, 32'h0000_0001);
        rd(`RTCT_OFS_STAMP);
    endtask : clear_tamper
    task automatic t_rising;
        wr(`RTCT_OFS_TCTRL, 32'h0000_0000);
        src.set_pin(1'b1);
        repeat (4) @(posedge clk_in);
        wr(`RTCT_OFS_TCTRL, 32'h0000_0002);
        repeat (10) @(posedge clk_in);
        #1 cmp("irq_false_edge", 32'h1, irq_out);
        clear_tamper();
        repeat (2) @(posedge clk_in);
        #1 cmp("irq_false_dropped", 32'h0, irq_out);
        pulse_tamper(1'b0);
        #1 cmp("irq_rise", 32'h1, irq_out);
        clear_tamper();
    endtask : t_rising
    task automatic t_ext_reset;
        logic [31:0] s;
        rd(`RTCT_OFS_STAMP);
        s = d;
        pulse_tamper(1'b1);
        #1 cmp("irq_aborted", 32'h0, irq_out);
        pulse_tamper(1'b0);
        #1 cmp("irq_after_abort", 32'h1, irq_out);
        rd(`RTCT_OFS_STAMP);
        cmp("stamp_kept", s, d);
        clear_tamper();
    endtask : t_ext_reset
    task automatic t_layer;
        logic [31:0] s;
        wr(`RTCT_OFS_CTRL, 32'h0000_0000);
        repeat (3) @(posedge clk_in);
        wr(`RTCT_OFS_TCTRL, 32'h0000_0003);
        pulse_tamper(1'b0);
        rd(`RTCT_OFS_FLAG);
        cmp("layer_flag", 32'h0, d & 32'h1);
        rd(`RTCT_OFS_TID);
        cmp("layer_id", 32'h0, d & 32'h1);
        wr(`RTCT_OFS_CTRL, 32'h0000_0003);
        repeat (10) @(posedge clk_in);
        clear_tamper();
        s = d;
        pulse_tamper(1'b0);
        #1 cmp("irq_layer_on", 32'h1, irq_out);
        rd(`RTCT_OFS_STAMP);
        cmp("stamp_unlocked", 32'h1, d != s);
    endtask : t_layer
    initial begin
        miscompares = 0; check_count = 0; rst_b_in = 1'b0;
        wr_in = 1'b0; rd_in = 1'b0; addr_in = 6'h00; wdata_in = 32'h0;
        repeat (12) @(posedge clk_in);
        rst_b_in <= 1'b1;
        t_reset_and_sync();
        t_count();
        t_periodic();
        t_tamper();
        t_rising();
        t_ext_reset();
        t_layer();
        report_and_stop();
    end
    initial begin
        #100us;
        miscompares++;
        report_and_stop();
    end
endmodule : rtc_counter_tamper_detect_tb
